// ==== aon_realtime_counter.sv ====
`timescale 1ns/100ps

// How it works
// - count advances by one per low-frequency tick, only while enabled
// - low count register shows count bits 31 to 0
// - high count register shows the upper 16 count bits
// - both count registers are read and written by software
// - run-continuously bit enables counting; reset clears it
// - 4-bit scale picks start bit of 32-bit scaled compare value
// - scale zero makes scaled value equal the low count word
// - scale up to 15, dividing the tick rate by up to two to the fifteenth
// - scaled value is readable as its own register
// - pending flag raised while scaled value is at least the compare value
// - pending flag is read-only; writes to it change nothing
// - writing a compare value above the scaled value drops the flag
// - pending flag drives the wakeup output to the power manager
module aon_realtime_counter
    import aon_rtc_pkg::*;
#(
    parameter int COUNT_WIDTH = 48
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic lfClkPin,
    input wire logic wrEn,
    input wire logic rdEn,
    input wire logic [ADDR_WIDTH-1:0] addr,
    input wire logic [WORD_WIDTH-1:0] wrData,
    output logic [WORD_WIDTH-1:0] rdData,
    output logic rdValid,
    output logic wakeupOut
);

    typedef struct packed {
        logic [COUNT_WIDTH-1:0] count;
        logic [SCALE_WIDTH-1:0] scale;
        logic runAlways;
        logic [WORD_WIDTH-1:0] cmp;
        logic pending;
        logic [WORD_WIDTH-1:0] rdData;
        logic rdValid;
    } rtc_state_type;

    rtc_state_type s_q;
    rtc_state_type s_d;
    logic tick;
    logic [WORD_WIDTH-1:0] scaledNow;
    reg_sel_type wrSel;
    reg_sel_type rdSel;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic reg_sel_type decodeAddr(input logic [ADDR_WIDTH-1:0] a);
        reg_sel_type sel;
        sel = SEL_NONE;
        case (a)
            CFG_OFFSET: sel = SEL_CFG;
            COUNT_LO_OFFSET: sel = SEL_COUNT_LO;
            COUNT_HI_OFFSET: sel = SEL_COUNT_HI;
            SCALED_OFFSET: sel = SEL_SCALED;
            CMP_OFFSET: sel = SEL_CMP;
            default: sel = SEL_NONE;
        endcase
        return sel;
    endfunction

    // the window never runs past the top since scale stops at 15
    function automatic logic [WORD_WIDTH-1:0] scaledOf(
        input logic [COUNT_WIDTH-1:0] cnt,
        input logic [SCALE_WIDTH-1:0] sc
    );
        logic [COUNT_WIDTH-1:0] shifted;
        shifted = cnt >> sc;
        return shifted[WORD_WIDTH-1:0];
    endfunction

    function automatic logic [WORD_WIDTH-1:0] cfgWord(input rtc_state_type st);
        logic [WORD_WIDTH-1:0] w;
        w = WORD_ZERO;
        w[CFG_SCALE_LSB +: SCALE_WIDTH] = st.scale;
        w[CFG_RUN_BIT] = st.runAlways;
        w[CFG_PENDING_BIT] = st.pending;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // low-frequency tick

    lf_tick_sync u_tick
    (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .lfClkPin(lfClkPin),
        .tick(tick)
    );

    assign wrSel = wrEn ? decodeAddr(addr) : SEL_NONE;
    assign rdSel = rdEn ? decodeAddr(addr) : SEL_NONE;
    assign scaledNow = scaledOf(s_q.count, s_q.scale);

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        s_d = s_q;
        s_d.rdValid = rdEn;

        // full-width add so the low-word carry lands in the high bits at once
        if (tick && s_q.runAlways)
        begin
            s_d.count = s_q.count + COUNT_WIDTH'(1);
        end

        // a software load beats a tick only in the count half it writes; the other half keeps the tick
        case (wrSel)
            SEL_CFG:
            begin
                // pending bit and reserved bits are not stored
                s_d.scale = wrData[CFG_SCALE_LSB +: SCALE_WIDTH];
                s_d.runAlways = wrData[CFG_RUN_BIT];
            end
            SEL_COUNT_LO:
            begin
                s_d.count[WORD_WIDTH-1:0] = wrData;
            end
            SEL_COUNT_HI:
            begin
                s_d.count[COUNT_WIDTH-1:WORD_WIDTH] =
                    wrData[COUNT_WIDTH-WORD_WIDTH-1:0];
            end
            SEL_CMP:
            begin
                s_d.cmp = wrData;
            end
            default:
            begin
            end
        endcase

        // compare follows the new count, scale and compare value
        s_d.pending = scaledOf(s_d.count, s_d.scale) >= s_d.cmp;

        s_d.rdData = WORD_ZERO;
        case (rdSel)
            SEL_CFG: s_d.rdData = cfgWord(s_q);
            SEL_COUNT_LO: s_d.rdData = s_q.count[WORD_WIDTH-1:0];
            SEL_COUNT_HI:
                s_d.rdData = WORD_WIDTH'(s_q.count[COUNT_WIDTH-1:WORD_WIDTH]);
            SEL_SCALED: s_d.rdData = scaledNow;
            SEL_CMP: s_d.rdData = s_q.cmp;
            default: s_d.rdData = WORD_ZERO;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s_q.count <= '0;
            s_q.scale <= SCALE_RESET;
            s_q.runAlways <= RUN_RESET;
            s_q.cmp <= CMP_RESET;
            s_q.pending <= 1'b0;
            s_q.rdData <= WORD_ZERO;
            s_q.rdValid <= 1'b0;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    assign rdData = s_q.rdData;
    assign rdValid = s_q.rdValid;
    assign wakeupOut = s_q.pending;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    logic countWrite;
    assign countWrite = (wrSel == SEL_COUNT_LO) || (wrSel == SEL_COUNT_HI);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    property p_countAdvance;
        ce && tick && s_q.runAlways && !countWrite |=> s_q.count == $past(s_q.count) + 1;
    endproperty
    a_countAdvance: assert property (p_countAdvance) else $error("count missed a tick");

    property p_countIdle;
        ce && !(tick && s_q.runAlways) && !countWrite |=> $stable(s_q.count);
    endproperty
    a_countIdle: assert property (p_countIdle) else $error("count moved while idle");

    property p_loRead;
        ce && rdSel == SEL_COUNT_LO |=> rdValid && rdData == $past(s_q.count[31:0]);
    endproperty
    a_loRead: assert property (p_loRead) else $error("low count read wrong");

    property p_hiRead;
        ce && rdSel == SEL_COUNT_HI |=> rdData == {16'h0000, $past(s_q.count[47:32])};
    endproperty
    a_hiRead: assert property (p_hiRead) else $error("high count read wrong");

    property p_loWrite;
        ce && wrSel == SEL_COUNT_LO |=> s_q.count[31:0] == $past(wrData);
    endproperty
    a_loWrite: assert property (p_loWrite) else $error("low count write lost");

    property p_scaleZero;
        s_q.scale == 4'h0 |-> scaledNow == s_q.count[31:0];
    endproperty
    a_scaleZero: assert property (p_scaleZero) else $error("unscaled value wrong");

    property p_scaleMax;
        s_q.scale == SCALE_MAX |-> scaledNow == s_q.count[46:15];
    endproperty
    a_scaleMax: assert property (p_scaleMax) else $error("scale 15 window wrong");

    property p_pending;
        s_q.pending == (scaledNow >= s_q.cmp);
    endproperty
    a_pending: assert property (p_pending) else $error("pending flag wrong");

    property p_cfgRead;
        ce && rdSel == SEL_CFG |=> (rdData & 32'hEFFFEFF0) == 32'h00000000
            && rdData[CFG_PENDING_BIT] == $past(s_q.pending);
    endproperty
    a_cfgRead: assert property (p_cfgRead) else $error("config read wrong");

    property p_clear;
        ce && wrSel == SEL_CMP && !tick && wrData > scaledNow |=> !wakeupOut;
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");

    property p_carry;
        ce && tick && s_q.runAlways && !countWrite && s_q.count[31:0] == 32'hFFFFFFFF
            |=> s_q.count[47:32] == $past(s_q.count[47:32]) + 16'h0001;
    endproperty
    a_carry: assert property (p_carry) else $error("carry not applied");

    // a compare value at or below the window must rouse the power manager
    property p_wakeup;
        ce && wrSel == SEL_CMP && !tick && wrData <= scaledNow |=> wakeupOut;
    endproperty
    a_wakeup: assert property (p_wakeup) else $error("wakeup not raised");

    property p_hiWrite;
        ce && wrSel == SEL_COUNT_HI |=> s_q.count[COUNT_WIDTH-1:WORD_WIDTH]
            == $past(wrData[COUNT_WIDTH-WORD_WIDTH-1:0]);
    endproperty
    a_hiWrite: assert property (p_hiWrite) else $error("high count write lost");

    property p_scaledRead;
        ce && rdSel == SEL_SCALED
            |=> rdData == WORD_WIDTH'($past(s_q.count) >> $past(s_q.scale));
    endproperty
    a_scaledRead: assert property (p_scaledRead) else $error("scaled read wrong");

    property p_runWrite;
        ce && wrSel == SEL_CFG |=> s_q.runAlways == $past(wrData[CFG_RUN_BIT]);
    endproperty
    a_runWrite: assert property (p_runWrite) else $error("run bit write lost");

    // same scale, no count movement: a config write must leave the flag alone
    property p_pendingHeld;
        ce && wrSel == SEL_CFG && wrData[CFG_SCALE_LSB +: SCALE_WIDTH] == s_q.scale
            && !(tick && s_q.runAlways) |=> wakeupOut == $past(wakeupOut);
    endproperty
    a_pendingHeld: assert property (p_pendingHeld) else $error("flag written");

    property p_cmpWrite;
        ce && wrSel == SEL_CMP |=> s_q.cmp == $past(wrData);
    endproperty
    a_cmpWrite: assert property (p_cmpWrite) else $error("compare write lost");

    property p_freeze;
        !ce |=> $stable(s_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    property p_readAnswer;
        ce |=> rdValid == $past(rdEn);
    endproperty
    a_readAnswer: assert property (p_readAnswer) else $error("read answer wrong");

    property p_unmappedRead;
        ce && rdEn && rdSel == SEL_NONE |=> rdData == WORD_ZERO;
    endproperty
    a_unmappedRead: assert property (p_unmappedRead) else $error("unmapped read");

    // a stuck tick would count on every clock
    property p_tickOnce;
        ce && tick |=> !tick;
    endproperty
    a_tickOnce: assert property (p_tickOnce) else $error("tick longer than a cycle");

    c_tickCount: cover property (ce && tick && s_q.runAlways);
    c_pendingRise: cover property (!wakeupOut ##1 wakeupOut);
    c_pendingClear: cover property (wakeupOut ##1 !wakeupOut);
    c_carry: cover property (ce && tick && s_q.runAlways && s_q.count[31:0] == 32'hFFFFFFFF);
    c_freeze: cover property (!ce ##1 ce);

endmodule

// ==== aon_rtc_pkg.sv ====
package aon_rtc_pkg;

    // register byte offsets
    localparam logic [7:0] CFG_OFFSET = 8'h40;
    localparam logic [7:0] COUNT_LO_OFFSET = 8'h48;
    localparam logic [7:0] COUNT_HI_OFFSET = 8'h4C;
    localparam logic [7:0] SCALED_OFFSET = 8'h50;
    localparam logic [7:0] CMP_OFFSET = 8'h60;

    // widths
    localparam int WORD_WIDTH = 32;
    localparam int HI_WIDTH = 16;
    localparam int SCALE_WIDTH = 4;
    localparam int ADDR_WIDTH = 8;
    localparam int SYNC_STAGES = 3;

    // configuration field positions
    localparam int CFG_SCALE_LSB = 0;
    localparam int CFG_RUN_BIT = 12;
    localparam int CFG_PENDING_BIT = 28;

    // largest scale setting
    localparam logic [3:0] SCALE_MAX = 4'hF;

    // reset values
    localparam logic [3:0] SCALE_RESET = 4'h0;
    localparam logic RUN_RESET = 1'b0;
    localparam logic [31:0] CMP_RESET = 32'hFFFFFFFF;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;
    localparam logic [31:0] WORD_ONES = 32'hFFFFFFFF;

    // register selector
    typedef enum {
        SEL_NONE,
        SEL_CFG,
        SEL_COUNT_LO,
        SEL_COUNT_HI,
        SEL_SCALED,
        SEL_CMP
    } reg_sel_type;

endpackage

// ==== lf_tick_sync.sv ====
`timescale 1ns/100ps

module lf_tick_sync
    import aon_rtc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic lfClkPin,
    output logic tick
);

    typedef struct packed {
        logic [SYNC_STAGES-1:0] sync;
        logic level;
        logic tick;
    } sync_state_type;

    sync_state_type s_q;
    sync_state_type s_d;

    ////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        s_d = s_q;
        s_d.sync = {s_q.sync[SYNC_STAGES-2:0], lfClkPin};
        s_d.tick = 1'b0;
        // stage 0 is metastable; only stages 1 and 2 are looked at
        if (s_q.sync[1] == s_q.sync[2])
        begin
            s_d.level = s_q.sync[2];
            s_d.tick = s_q.sync[2] && !s_q.level;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s_q <= '0;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

endmodule

// ==== tb_top.sv ====
`timescale 1ns/100ps
module tb_top
    import aon_rtc_pkg::*;
;
    `define CHK(nm, e, g) \
        begin \
            n_tests++; \
            if ((g) !== (e)) \
            begin \
                n_mismatch++; \
                $display("[ERR] %s expected %h seen %h", nm, e, g); \
            end \
        end
    ////////////////////////////////////////////////////////////
    logic clk, nrst, ce, lfClkPin, wrEn, rdEn, rdValid, wakeupOut;
    logic [7:0] addr;
    logic [31:0] wrData, rdData, v, w, monE;
    logic [47:0] full, sv;
    string monN;
    int n_mismatch = 0;
    int n_tests = 0;
    integer seed = 32'h1C093FF7;
    logic [31:0] expQ[$];
    string nameQ[$];

    aon_realtime_counter #(.COUNT_WIDTH(48)) u_aon_realtime_counter (
        .clk(clk), .nrst(nrst), .ce(ce), .lfClkPin(lfClkPin), .wrEn(wrEn),
        .rdEn(rdEn), .addr(addr), .wrData(wrData), .rdData(rdData),
        .rdValid(rdValid), .wakeupOut(wakeupOut));

    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        wrEn = 1'b1;
        addr = a;
        wrData = d;
        @(negedge clk);
        wrEn = 1'b0;
    endtask

    // expectation noted when the strobe goes out; monitor pairs it later
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(negedge clk);
        rdEn = 1'b1;
        addr = a;
        expQ.push_back(e);
        nameQ.push_back(nm);
        @(negedge clk);
        rdEn = 1'b0;
    endtask

    // pin held well over the three-stage synchroniser depth
    task automatic pulse();
        @(negedge clk);
        lfClkPin = 1'b1;
        repeat (6) @(negedge clk);
        lfClkPin = 1'b0;
        repeat (6) @(negedge clk);
    endtask

    task automatic results();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk)
    begin
        if (rdValid === 1'b1)
        begin
            if (expQ.size() == 0)
            begin
                n_mismatch++;
                $display("[ERR] rdValid expected 0 seen 1");
            end
            else
            begin
                monE = expQ.pop_front();
                monN = nameQ.pop_front();
                `CHK(monN, monE, rdData)
            end
        end
    end

    initial
    begin
        #200000;
        n_mismatch++;
        results();
    end
    ////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        nrst = 1'b0;
        ce = 1'b1;
        lfClkPin = 1'b0;
        wrEn = 1'b0;
        rdEn = 1'b0;
        addr = 8'h00;
        wrData = 32'h0;
        repeat (8) @(negedge clk);
        nrst = 1;
        rd("cfg", CFG_OFFSET, WORD_ZERO);
        rd("lo", COUNT_LO_OFFSET, WORD_ZERO);
        rd("cmp", CMP_OFFSET, CMP_RESET);
        rd("unmapped", 8'h44, WORD_ZERO);
        `CHK("wakeupOut", 1'b0, wakeupOut)
        $display("test reset done");
        // all ones: only scale and run may stick, pending stays low
        wr(CFG_OFFSET, WORD_ONES);
        rd("cfg", CFG_OFFSET, 32'h0000100F);
        wr(CFG_OFFSET, WORD_ZERO);
        $display("test reserved done");
        v = $random(seed);
        w = $random(seed);
        wr(COUNT_LO_OFFSET, v);
        wr(COUNT_HI_OFFSET, w);
        wr(8'h44, w);
        pulse();
        rd("lo", COUNT_LO_OFFSET, v);
        rd("hi", COUNT_HI_OFFSET, {16'h0000, w[15:0]});
        $display("test count regs done");
        wr(COUNT_LO_OFFSET, 32'hFFFFFFFE);
        wr(COUNT_HI_OFFSET, 32'h00001234);
        wr(CFG_OFFSET, 32'h00001000);
        repeat (3) pulse();
        wr(CFG_OFFSET, WORD_ZERO);
        rd("lo", COUNT_LO_OFFSET, 32'h00000001);
        rd("hi", COUNT_HI_OFFSET, 32'h00001235);
        $display("test counting done");
        // clock enable low: neither the strobe nor the pin pulse is taken
        wr(CFG_OFFSET, 32'h00001000);
        @(negedge clk);
        ce = 1'b0;
        wr(COUNT_LO_OFFSET, WORD_ONES);
        pulse();
        ce = 1'b1;
        wr(CFG_OFFSET, WORD_ZERO);
        rd("lo", COUNT_LO_OFFSET, 32'h00000001);
        $display("test freeze done");
        for (int s = 0; s < 16; s++)
        begin
            full[31:0] = $random(seed);
            full[47:32] = 16'($random(seed));
            wr(COUNT_LO_OFFSET, full[31:0]);
            wr(COUNT_HI_OFFSET, {16'h0000, full[47:32]});
            wr(CFG_OFFSET, {28'h0, 4'(s)});
            sv = full >> s;
            rd("scaled", SCALED_OFFSET, sv[31:0]);
        end
        $display("test scale done");
        // equal counts as reached; one above clears
        v = $random(seed) & 32'h7FFFFFFF;
        wr(CFG_OFFSET, WORD_ZERO);
        wr(COUNT_LO_OFFSET, v);
        wr(COUNT_HI_OFFSET, WORD_ZERO);
        wr(CMP_OFFSET, v);
        repeat (2) @(negedge clk);
        `CHK("wakeupOut", 1'b1, wakeupOut)
        rd("cfg", CFG_OFFSET, 32'h10000000);
        wr(CFG_OFFSET, WORD_ZERO);
        rd("cfg", CFG_OFFSET, 32'h10000000);
        wr(CMP_OFFSET, v + 32'h1);
        rd("cmp", CMP_OFFSET, v + 32'h1);
        rd("cfg", CFG_OFFSET, WORD_ZERO);
        repeat (2) @(negedge clk);
        `CHK("wakeupOut", 1'b0, wakeupOut)
        $display("test compare done");
        repeat (4) @(negedge clk);
        `CHK("pending reads", 0, expQ.size())
        results();
    end
endmodule
